// *** rtcam_pkg.sv ***
// rtcam_pkg: register map, field layout, reset values and constants of the alarm match block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package rtcam_pkg;

    // ********************************************
    // register indices, byte address is four times the index
    // ********************************************
    localparam logic [7:0] IDX_MINUTE_ALARM = 8'h0a;
    localparam logic [7:0] IDX_HOUR_ALARM = 8'h0b;
    localparam logic [7:0] IDX_DAY_ALARM = 8'h0c;
    localparam logic [7:0] IDX_WEEKDAY_ALARM = 8'h0d;
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h11;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h12;

    // ********************************************
    // field positions and widths
    // ********************************************
    localparam int MATCH_DISABLE_BIT = 7;
    localparam int MERIDIEM_BIT = 5;
    localparam int CTRL_HOUR12_BIT = 0;
    localparam int IRQ_ALARM_BIT = 0;

    localparam logic [7:0] MINUTE_MASK = 8'h7f;
    localparam logic [7:0] HOUR12_MASK = 8'h3f;
    localparam logic [7:0] HOUR24_MASK = 8'h3f;
    localparam logic [7:0] DAY_MASK = 8'h3f;
    localparam logic [7:0] WEEKDAY_MASK = 8'h07;
    localparam logic [7:0] ENABLE_MASK = 8'h80;
    localparam logic [7:0] CONTROL_MASK = 8'h01;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h01;

    // ********************************************
    // reset values
    // ********************************************
    localparam logic [7:0] ALARM_RESET = 8'h80;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // ********************************************
    // bus answer states
    // ********************************************
    typedef enum logic [0:0] {
        RTCAM_IDLE,
        RTCAM_ACK
    } rtcam_bus_state_t;

endpackage

// *** rtcam_field_match.sv ***
// rtcam_field_match: compares one alarm field with the current time field
// masks both values with field_mask_i, so bits outside the field never take part in the compare
`timescale 1ns/100ps
`default_nettype none
module rtcam_field_match (
    input wire logic [7:0] setting_i,
    input wire logic [7:0] current_i,
    input wire logic [7:0] field_mask_i,
    output logic enabled_o,
    output logic equal_o
);
    // active-low enable in the top bit
    assign enabled_o = ~setting_i[rtcam_pkg::MATCH_DISABLE_BIT];
    assign equal_o = (setting_i & field_mask_i) == (current_i & field_mask_i);
endmodule // rtcam_field_match
`default_nettype wire

// *** rtcam_sticky_bit.sv ***
// rtcam_sticky_bit: one interrupt status bit, set by an event, cleared by writing one
// assumes set and clear are one-cycle pulses on clk_i
`timescale 1ns/100ps
`default_nettype none
module rtcam_sticky_bit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    logic flag_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flag_reg <= 1'b0;
        else if (set_i)
            flag_reg <= 1'b1;
        // set outranks a clear landing in the same cycle
        else if (clear_i)
            flag_reg <= 1'b0;
    end
    assign flag_o = flag_reg;
endmodule // rtcam_sticky_bit
`default_nettype wire

// *** rtcam_alarm_match.sv ***
// rtcam_alarm_match: alarm setting registers with match logic and interrupt
// assumes a classic wishbone master and current time fields from the time counters, in BCD
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE_01 - minute alarm bit 7 is active-low enable, resets to one
// RULE_02 - minute alarm holds BCD minute in bits 6 to 0
// RULE_03 - hour alarm bit 7 active-low enable resetting to one, bit 6 unused
// RULE_04 - in 12-hour mode bit 5 is meridiem, bits 4 to 0 hour
// RULE_05 - in 24-hour mode bits 5 to 0 hold BCD hour 0 to 23
// RULE_06 - one hour-format control bit selects the hour alarm layout
// RULE_07 - day alarm bit 7 enable, bit 6 unused, bits 5 to 0 day
// RULE_08 - weekday alarm bit 7 enable, bits 6 to 3 unused, 2 to 0 weekday
// RULE_09 - weekday codes are only compared, meaning left to the user
// RULE_10 - alarm registers sit at indices 0ah to 0dh in order
// RULE_11 - alarm when all enabled fields match; none enabled gives no alarm
module rtcam_alarm_match (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] cur_minute_i,
    input wire logic [7:0] cur_hour_i,
    input wire logic [7:0] cur_day_i,
    input wire logic [7:0] cur_weekday_i,
    input wire logic second_tick_i,
    output logic alarm_pulse_o,
    output logic hour12_mode_o,
    output logic irq_o
);

    // ********************************************
    // storage
    // ********************************************
    logic [7:0] minute_alarm_setting_reg;
    logic [7:0] hour_alarm_setting_reg;
    logic [7:0] day_alarm_setting_reg;
    logic [7:0] weekday_alarm_setting_reg;
    logic [7:0] control_reg;
    logic [7:0] irq_mask_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic alarm_pulse_reg;
    logic irq_reg;
    logic match_hold_reg;
    rtcam_pkg::rtcam_bus_state_t bus_state_reg;

    logic bus_req;
    logic wr_strobe;
    logic [7:0] reg_index;
    logic addr_aligned;
    logic lane0_wr;
    logic [7:0] wdata8;
    logic [7:0] hour_field_mask;
    logic [7:0] irq_status;
    logic [31:0] rdata_next;
    logic irq_clear;

    // ********************************************
    // bus decode
    // ********************************************
    // a request held through its answer cycle is not taken twice
    assign bus_req = wb_cyc_i & wb_stb_i & (bus_state_reg == rtcam_pkg::RTCAM_IDLE);
    assign reg_index = wb_adr_i[9:2];
    // out-of-range upper address bits alias nothing, they read zero
    assign addr_aligned = (wb_adr_i[31:10] == 22'h000000);
    assign wr_strobe = bus_req & wb_we_i & addr_aligned;
    // registers are eight bits wide in lane 0; other lanes are ignored
    assign lane0_wr = wr_strobe & wb_sel_i[0];
    assign wdata8 = wb_dat_i[7:0];

    // one wait state: ack follows the request edge, then drops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_state_reg <= rtcam_pkg::RTCAM_IDLE;
        else
        begin
            case (bus_state_reg)
                rtcam_pkg::RTCAM_IDLE:
                    if (bus_req)
                        bus_state_reg <= rtcam_pkg::RTCAM_ACK;
                rtcam_pkg::RTCAM_ACK:
                    bus_state_reg <= rtcam_pkg::RTCAM_IDLE;
                default:
                    bus_state_reg <= rtcam_pkg::RTCAM_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= bus_req;
    end
    assign wb_ack_o = ack_reg;

    // ********************************************
    // alarm setting registers
    // ********************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // every field comes up excluded from the match
            minute_alarm_setting_reg <= rtcam_pkg::ALARM_RESET; // [RULE_01]
            hour_alarm_setting_reg <= rtcam_pkg::ALARM_RESET; // [RULE_03]
            day_alarm_setting_reg <= rtcam_pkg::ALARM_RESET; // [RULE_07]
            weekday_alarm_setting_reg <= rtcam_pkg::ALARM_RESET; // [RULE_08]
        end
        else if (lane0_wr)
        begin
            case (reg_index) // [RULE_10]
                rtcam_pkg::IDX_MINUTE_ALARM:
                begin
                    minute_alarm_setting_reg <= wdata8 & (rtcam_pkg::ENABLE_MASK | rtcam_pkg::MINUTE_MASK); // [RULE_02]
                end
                rtcam_pkg::IDX_HOUR_ALARM:
                begin
                    // bit 6 never stored, bit 5 kept in both layouts
                    hour_alarm_setting_reg <= wdata8 & (rtcam_pkg::ENABLE_MASK | rtcam_pkg::HOUR24_MASK); // [RULE_03]
                end
                rtcam_pkg::IDX_DAY_ALARM:
                begin
                    day_alarm_setting_reg <= wdata8 & (rtcam_pkg::ENABLE_MASK | rtcam_pkg::DAY_MASK); // [RULE_07]
                end
                rtcam_pkg::IDX_WEEKDAY_ALARM:
                begin
                    weekday_alarm_setting_reg <= wdata8 & (rtcam_pkg::ENABLE_MASK | rtcam_pkg::WEEKDAY_MASK); // [RULE_08]
                end
                // other indices leave the alarm settings untouched
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            control_reg <= rtcam_pkg::CONTROL_RESET;
        else if (lane0_wr && reg_index == rtcam_pkg::IDX_CONTROL)
            // only the format bit is stored, the rest reads zero
            control_reg <= wdata8 & rtcam_pkg::CONTROL_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask_reg <= rtcam_pkg::IRQ_MASK_RESET;
        else if (lane0_wr && reg_index == rtcam_pkg::IDX_IRQ_MASK)
            irq_mask_reg <= wdata8 & rtcam_pkg::IRQ_BITS_MASK;
    end

    // a clear in the cycle of a new event loses, so no alarm is missed
    assign irq_clear = lane0_wr && reg_index == rtcam_pkg::IDX_IRQ_STATUS && wdata8[rtcam_pkg::IRQ_ALARM_BIT];

    // ********************************************
    // match logic
    // ********************************************
    // 12-hour layout: meridiem in bit 5 and hour in 4:0, both compared
    assign hour_field_mask = control_reg[rtcam_pkg::CTRL_HOUR12_BIT] ?
        rtcam_pkg::HOUR12_MASK : rtcam_pkg::HOUR24_MASK; // [RULE_04] [RULE_05] [RULE_06]

    logic [3:0] fld_en;
    logic [3:0] fld_eq;

    rtcam_field_match u_minute (
        .setting_i(minute_alarm_setting_reg),
        .current_i(cur_minute_i),
        .field_mask_i(rtcam_pkg::MINUTE_MASK),
        .enabled_o(fld_en[0]),
        .equal_o(fld_eq[0])
    );
    rtcam_field_match u_hour (
        .setting_i(hour_alarm_setting_reg),
        .current_i(cur_hour_i),
        .field_mask_i(hour_field_mask),
        .enabled_o(fld_en[1]),
        .equal_o(fld_eq[1])
    );
    rtcam_field_match u_day (
        .setting_i(day_alarm_setting_reg),
        .current_i(cur_day_i),
        .field_mask_i(rtcam_pkg::DAY_MASK),
        .enabled_o(fld_en[2]),
        .equal_o(fld_eq[2])
    );
    // weekday is a plain code compare, no calendar meaning implied
    rtcam_field_match u_weekday (
        .setting_i(weekday_alarm_setting_reg),
        .current_i(cur_weekday_i),
        .field_mask_i(rtcam_pkg::WEEKDAY_MASK),
        .enabled_o(fld_en[3]),
        .equal_o(fld_eq[3])
    ); // [RULE_09]

    // invalid bcd settings compare as written, no range check
    logic match_now;
    assign match_now = (|fld_en) && ((fld_eq | ~fld_en) == 4'hf); // [RULE_11]

    // one event per entry into a match, sampled on the second tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_hold_reg <= 1'b0;
        else if (second_tick_i)
            match_hold_reg <= match_now;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alarm_pulse_reg <= 1'b0;
        else
            alarm_pulse_reg <= second_tick_i & match_now & ~match_hold_reg; // [RULE_11]
    end
    assign alarm_pulse_o = alarm_pulse_reg;

    // the format output trails the control bit by one cycle
    logic hour12_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hour12_reg <= 1'b0;
        else
            hour12_reg <= control_reg[rtcam_pkg::CTRL_HOUR12_BIT]; // [RULE_06]
    end
    assign hour12_mode_o = hour12_reg;

    // ********************************************
    // interrupt
    // ********************************************
    // status bit 0 is the only event source
    logic alarm_flag;
    rtcam_sticky_bit u_alarm_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(alarm_pulse_reg),
        .clear_i(irq_clear),
        .flag_o(alarm_flag)
    );
    // irq follows status and mask one cycle late
    assign irq_status = {7'h00, alarm_flag};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(irq_status & irq_mask_reg);
    end
    assign irq_o = irq_reg;

    // ********************************************
    // read data
    // ********************************************
    // read data is captured at the taking edge and held until the next request
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (addr_aligned)
        begin
            case (reg_index)
                rtcam_pkg::IDX_MINUTE_ALARM:
                    rdata_next[7:0] = minute_alarm_setting_reg;
                rtcam_pkg::IDX_HOUR_ALARM:
                    rdata_next[7:0] = hour_alarm_setting_reg;
                rtcam_pkg::IDX_DAY_ALARM:
                    rdata_next[7:0] = day_alarm_setting_reg;
                rtcam_pkg::IDX_WEEKDAY_ALARM:
                    rdata_next[7:0] = weekday_alarm_setting_reg;
                rtcam_pkg::IDX_CONTROL:
                    rdata_next[7:0] = control_reg;
                rtcam_pkg::IDX_IRQ_STATUS:
                    rdata_next[7:0] = irq_status;
                rtcam_pkg::IDX_IRQ_MASK:
                    rdata_next[7:0] = irq_mask_reg;
                default:
                    rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= 32'h00000000;
        else if (bus_req)
            rdata_reg <= rdata_next;
    end
    assign wb_dat_o = rdata_reg;

endmodule // rtcam_alarm_match
`default_nettype wire

// *** rtcam_alarm_match_props.sv ***
// rtcam_alarm_match_props: port checks of the alarm match block
// assumes only the top ports, bound below
`timescale 1ns/100ps
`default_nettype none
module rtcam_alarm_match_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic second_tick_i,
    input wire logic alarm_pulse_o,
    input wire logic hour12_mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ********************************************
    // sequences
    // ********************************************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd;
        wb_ack_o && !wb_we_i;
    endsequence
    sequence s_ctrl_wr;
        s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 32'h40);
    endsequence
    // ********************************************
    // properties
    // ********************************************
    property p_ack_answer;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_stb_i);
    endproperty
    property p_upper_zero;
        s_rd |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    property p_unmapped;
        s_rd ##0 (wb_adr_i[31:10] != 22'h0) |-> wb_dat_o == 32'h0;
    endproperty
    property p_bit6_unused;
        s_rd ##0 (wb_adr_i == 32'h2c || wb_adr_i == 32'h30) |-> !wb_dat_o[6];
    endproperty
    property p_weekday_unused;
        s_rd ##0 (wb_adr_i == 32'h34) |-> wb_dat_o[6:3] == 4'h0;
    endproperty
    property p_hour_mode;
        s_ctrl_wr |=> ##1 hour12_mode_o == $past(wb_dat_i[0], 2);
    endproperty
    property p_alarm_cause;
        alarm_pulse_o |-> $past(second_tick_i);
    endproperty
    property p_alarm_once;
        alarm_pulse_o |=> !alarm_pulse_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_bit6_unused: assert property (p_bit6_unused) else $error("bit 6 set");
    a_weekday_unused: assert property (p_weekday_unused) else $error("weekday spare bits");
    a_hour_mode: assert property (p_hour_mode) else $error("hour mode wrong");
    a_alarm_cause: assert property (p_alarm_cause) else $error("pulse without tick");
    a_alarm_once: assert property (p_alarm_once) else $error("pulse too long");
endmodule // rtcam_alarm_match_props

bind rtcam_alarm_match rtcam_alarm_match_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .second_tick_i(second_tick_i), .alarm_pulse_o(alarm_pulse_o), .hour12_mode_o(hour12_mode_o));
`default_nettype wire

// *** rtcam_alarm_match_test.sv ***
// rtcam_alarm_match_test: self-checking bench of the alarm match block
// assumes registered alarm outputs; bus waits end only by the watchdog
`timescale 1ns/100ps
`default_nettype none
module rtcam_alarm_match_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, rdat, rd, v;
    logic [3:0] sel = 4'h1;
    logic [7:0] cm = 8'hff, ch = 8'hff, cd = 8'hff, cw = 8'hff;
    logic ack, pulse, h12, irq;
    logic [31:0] seed = 32'h66e12907;
    int bad_count = 0;
    int checked = 0;

    rtcam_alarm_match dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cur_minute_i(cm), .cur_hour_i(ch), .cur_day_i(cd), .cur_weekday_i(cw),
        .second_tick_i(tick), .alarm_pulse_o(pulse), .hour12_mode_o(h12), .irq_o(irq));

    always #5 clk_i = ~clk_i;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // stored bits of each alarm register, spare bits read back as zero
    function logic [7:0] keep(input int i);
        return (i == 0) ? 8'hff : (i == 3) ? 8'h87 : 8'hbf;
    endfunction

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // no cycle limit here: only the watchdog ends a wait
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // time fields change at the same edge that raises the tick
    task tick_chk(input logic [31:0] cur, input logic exp);
        @(posedge clk_i);
        {cm, ch, cd, cw} <= cur;
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        #1 cmp({31'h0, pulse}, {31'h0, exp});
    endtask

    // a mismatching tick first, so the second tick is a fresh match
    task trial(input logic [31:0] cur, input logic exp);
        tick_chk(32'hffffffff, 1'b0);
        tick_chk(cur, exp);
    endtask

    task conclude();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, 32'h28 + 32'(i * 4), 32'h0);
            cmp(rd, (i < 4) ? 32'h80 : 32'h0);
        end
        sel <= 4'he;
        bus(1'b1, 32'h28, 32'h0);
        sel <= 4'h1;
        bus(1'b0, 32'h28, 32'h0);
        cmp(rd, 32'h80);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            v = rnd();
            bus(1'b1, 32'h28 + 32'(i * 4), v);
            bus(1'b0, 32'h28 + 32'(i * 4), 32'h0);
            cmp(rd, {24'h0, v[7:0] & keep(i)});
        end
        bus(1'b1, 32'h38, rnd());
        bus(1'b0, 32'h38, 32'h0);
        cmp(rd, 32'h0);
        bus(1'b0, 32'h428, 32'h0);
        cmp(rd, 32'h0);
        $display("register access done");
        bus(1'b1, 32'h48, 32'h1);
        for (int i = 0; i < 4; i++)
            bus(1'b1, 32'h28 + 32'(i * 4), 32'h80);
        trial(rnd(), 1'b0);
        bus(1'b1, 32'h28, 32'h37);
        v = rnd();
        trial({8'h37, v[23:0]}, 1'b1);
        repeat (2) @(posedge clk_i);
        #1 cmp({31'h0, irq}, 32'h1);
        tick_chk({8'h37, v[23:0]}, 1'b0);
        bus(1'b1, 32'h44, 32'h1);
        repeat (2) @(posedge clk_i);
        #1 cmp({31'h0, irq}, 32'h0);
        bus(1'b1, 32'h28, 32'h80);
        bus(1'b1, 32'h40, 32'h1);
        #1 cmp({31'h0, h12}, 32'h1);
        bus(1'b1, 32'h2c, 32'h25);
        trial(32'h00050000, 1'b0);
        trial(32'h00250000, 1'b1);
        bus(1'b1, 32'h40, 32'h0);
        bus(1'b1, 32'h2c, 32'h23);
        trial(32'h00230000, 1'b1);
        bus(1'b1, 32'h2c, 32'h80);
        v = rnd() % 7;
        bus(1'b1, 32'h30, 32'h31);
        bus(1'b1, 32'h34, v);
        trial({16'h0, 8'h31, v[7:0]}, 1'b1);
        trial({16'h0, 8'h31, 8'((v + 1) % 7)}, 1'b0);
        $display("alarm match done");
        conclude();
    end
endmodule // rtcam_alarm_match_test
`default_nettype wire
